// [design/hoist_brake_signal_control.sv]
// hoist brake signal control: release and apply qualification, axi4-lite
// assumes drive measurements and commands come from logic on clk
`timescale 1ns/1ns
`default_nettype none
//
// Contract
// R1 - release after a level held for timer
// R2 - current level 0..300 percent of rating
// R3 - frequency level 0..25.0 Hz, V/f only
// R4 - torque level 0..300 percent, vector only
// R5 - release timer 0..5.0 s, held throughout
// R6 - bit 2 picks slow filtered or quick
// R7 - bit 0 picks detected or reference speed
// R8 - bit 3 picks stop or apply frequency
// R9 - word 0..31, default 0, bit 1 unused
// R10 - terminal code 57 routes the brake signal
// R11 - V/f apply: run off, below level, timer
// R12 - bit 4 gates apply on run off
// R13 - shutdown, alarm or coast apply immediately
// R14 - other motors keep brake released
// R15 - timers restart when condition drops
// R16 - brake engaged after reset until qualified
module hoist_brake_signal_control #(
    parameter int TICK_CYCLES = hbsc_pkg::TICK_CYCLES
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [15:0] output_current,
    input wire logic [15:0] output_freq,
    input wire logic [15:0] torque_cmd,
    input wire logic [15:0] detected_speed,
    input wire logic [15:0] reference_speed,
    input wire logic vector_mode,
    input wire logic run_cmd,
    input wire logic output_shutdown,
    input wire logic alarm,
    input wire logic coast_cmd,
    input wire logic [1:0] motor_select,
    output logic brake_release_output,
    output logic dout_terminal
);

    function automatic logic [31:0] wmerge(input logic [31:0] old,
        input logic [31:0] data, input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = data[i*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic [15:0] sat16(input logic [31:0] v,
        input logic [15:0] lim);
        return (v > {16'h0000, lim}) ? lim : v[15:0];
    endfunction

    function automatic logic is_mapped(input logic [7:0] a);
        return a == hbsc_pkg::OFS_RELEASE_CURRENT ||
            a == hbsc_pkg::OFS_RELEASE_FREQ ||
            a == hbsc_pkg::OFS_RELEASE_TIMER ||
            a == hbsc_pkg::OFS_APPLY_FREQ ||
            a == hbsc_pkg::OFS_APPLY_TIMER ||
            a == hbsc_pkg::OFS_RELEASE_TORQUE ||
            a == hbsc_pkg::OFS_SPEED_SEL ||
            a == hbsc_pkg::OFS_STOP_FREQ ||
            a == hbsc_pkg::OFS_DOUT_FUNC ||
            a == hbsc_pkg::OFS_STATUS;
    endfunction

    // bus state
    logic aw_held, w_held;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic next_aw_held, next_w_held;
    logic [7:0] next_aw_addr;
    logic [31:0] next_w_data;
    logic [3:0] next_w_strb;
    logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
    logic [1:0] next_bresp, next_rresp;
    logic [31:0] next_rdata;
    logic do_write;

    // settings
    logic [15:0] cur_lvl, freq_lvl, rel_tmr, apply_freq, apply_tmr;
    logic [15:0] torque_lvl, stop_freq;
    logic [4:0] speed_sel;
    logic [7:0] dout_func;
    logic [15:0] next_cur_lvl, next_freq_lvl, next_rel_tmr, next_apply_freq;
    logic [15:0] next_apply_tmr, next_torque_lvl, next_stop_freq;
    logic [4:0] next_speed_sel;
    logic [7:0] next_dout_func;
    logic [31:0] wv;

    // brake logic
    hbsc_pkg::hbsc_state_type state, next_state;
    logic [15:0] filt_cur, next_filt_cur;
    logic signed [16:0] cur_diff;
    logic next_brake, next_dout;
    logic motor1, stop_event, rel_cond, apply_cond, run_ok;
    logic rel_q, apply_q;
    logic [15:0] cur_used, speed_cmp, apply_thr;
    logic [31:0] status;

    hbsc_timer_if rel_if();
    hbsc_timer_if apply_if();

    hbsc_qual_timer #(.TICK_CYCLES(TICK_CYCLES)) u_rel_timer (
        .clk(clk),
        .resetn(resetn),
        .tif(rel_if)
    );

    hbsc_qual_timer #(.TICK_CYCLES(TICK_CYCLES)) u_apply_timer (
        .clk(clk),
        .resetn(resetn),
        .tif(apply_if)
    );

    assign status = {28'h0000000, motor1, apply_cond, rel_cond,
        brake_release_output};

    // axi4-lite slave: one write and one read at a time
    always_comb begin
        next_aw_held = aw_held;
        next_w_held = w_held;
        next_aw_addr = aw_addr;
        next_w_data = w_data;
        next_w_strb = w_strb;
        next_bvalid = s_axi_bvalid;
        next_bresp = s_axi_bresp;
        next_rvalid = s_axi_rvalid;
        next_rresp = s_axi_rresp;
        next_rdata = s_axi_rdata;
        do_write = aw_held && w_held && !s_axi_bvalid;
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_held = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_held = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        if (do_write) begin
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = (is_mapped(aw_addr) &&
                aw_addr != hbsc_pkg::OFS_STATUS) ?
                hbsc_pkg::RESP_OKAY : hbsc_pkg::RESP_SLVERR;
        end
        if (s_axi_rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            next_rvalid = 1'b1;
            next_rresp = is_mapped(s_axi_araddr) ?
                hbsc_pkg::RESP_OKAY : hbsc_pkg::RESP_SLVERR;
            case (s_axi_araddr)
                hbsc_pkg::OFS_RELEASE_CURRENT: next_rdata = {16'h0000, cur_lvl};
                hbsc_pkg::OFS_RELEASE_FREQ: next_rdata = {16'h0000, freq_lvl};
                hbsc_pkg::OFS_RELEASE_TIMER: next_rdata = {16'h0000, rel_tmr};
                hbsc_pkg::OFS_APPLY_FREQ: next_rdata = {16'h0000, apply_freq};
                hbsc_pkg::OFS_APPLY_TIMER: next_rdata = {16'h0000, apply_tmr};
                hbsc_pkg::OFS_RELEASE_TORQUE: next_rdata = {16'h0000, torque_lvl};
                hbsc_pkg::OFS_SPEED_SEL: next_rdata = {27'h0000000, speed_sel};
                hbsc_pkg::OFS_STOP_FREQ: next_rdata = {16'h0000, stop_freq};
                hbsc_pkg::OFS_DOUT_FUNC: next_rdata = {24'h000000, dout_func};
                hbsc_pkg::OFS_STATUS: next_rdata = status;
                default: next_rdata = 32'h00000000;
            endcase
        end
        next_awready = !next_aw_held && !next_bvalid;
        next_wready = !next_w_held && !next_bvalid;
        next_arready = !next_rvalid;
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= 2'h0;
            s_axi_rdata <= 32'h00000000;
        end else begin
            aw_held <= next_aw_held;
            w_held <= next_w_held;
            aw_addr <= next_aw_addr;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            s_axi_awready <= next_awready;
            s_axi_wready <= next_wready;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp <= next_bresp;
            s_axi_arready <= next_arready;
            s_axi_rvalid <= next_rvalid;
            s_axi_rresp <= next_rresp;
            s_axi_rdata <= next_rdata;
        end
    end

    // settings, saturated to their ranges on write
    always_comb begin
        next_cur_lvl = cur_lvl;
        next_freq_lvl = freq_lvl;
        next_rel_tmr = rel_tmr;
        next_apply_freq = apply_freq;
        next_apply_tmr = apply_tmr;
        next_torque_lvl = torque_lvl;
        next_stop_freq = stop_freq;
        next_speed_sel = speed_sel;
        next_dout_func = dout_func;
        wv = 32'h00000000;
        if (do_write) begin
            case (aw_addr)
                // R2 current level range
                hbsc_pkg::OFS_RELEASE_CURRENT: begin
                    wv = wmerge({16'h0000, cur_lvl}, w_data, w_strb);
                    next_cur_lvl = sat16(wv, hbsc_pkg::PERCENT_MAX);
                end
                // R3 frequency level range
                hbsc_pkg::OFS_RELEASE_FREQ: begin
                    wv = wmerge({16'h0000, freq_lvl}, w_data, w_strb);
                    next_freq_lvl = sat16(wv, hbsc_pkg::FREQ_MAX);
                end
                // R5 release timer range
                hbsc_pkg::OFS_RELEASE_TIMER: begin
                    wv = wmerge({16'h0000, rel_tmr}, w_data, w_strb);
                    next_rel_tmr = sat16(wv, hbsc_pkg::TIMER_MAX);
                end
                hbsc_pkg::OFS_APPLY_FREQ: begin
                    wv = wmerge({16'h0000, apply_freq}, w_data, w_strb);
                    next_apply_freq = sat16(wv, hbsc_pkg::FREQ_MAX);
                end
                // R11 apply timer range
                hbsc_pkg::OFS_APPLY_TIMER: begin
                    wv = wmerge({16'h0000, apply_tmr}, w_data, w_strb);
                    next_apply_tmr = sat16(wv, hbsc_pkg::TIMER_MAX);
                end
                // R4 torque level range
                hbsc_pkg::OFS_RELEASE_TORQUE: begin
                    wv = wmerge({16'h0000, torque_lvl}, w_data, w_strb);
                    next_torque_lvl = sat16(wv, hbsc_pkg::PERCENT_MAX);
                end
                // R9 word limited to 0..31
                hbsc_pkg::OFS_SPEED_SEL: begin
                    wv = wmerge({27'h0000000, speed_sel}, w_data, w_strb);
                    next_speed_sel = 5'(sat16(wv, 16'(hbsc_pkg::SEL_MAX)));
                end
                hbsc_pkg::OFS_STOP_FREQ: begin
                    wv = wmerge({16'h0000, stop_freq}, w_data, w_strb);
                    next_stop_freq = sat16(wv, hbsc_pkg::FREQ_MAX);
                end
                hbsc_pkg::OFS_DOUT_FUNC: begin
                    wv = wmerge({24'h000000, dout_func}, w_data, w_strb);
                    next_dout_func = wv[7:0];
                end
                default: wv = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cur_lvl <= hbsc_pkg::PERCENT_RST;
            freq_lvl <= hbsc_pkg::FREQ_RST;
            rel_tmr <= hbsc_pkg::TIMER_RST;
            apply_freq <= hbsc_pkg::FREQ_RST;
            apply_tmr <= hbsc_pkg::TIMER_RST;
            torque_lvl <= hbsc_pkg::PERCENT_RST;
            stop_freq <= hbsc_pkg::STOP_FREQ_RST;
            speed_sel <= hbsc_pkg::SEL_RST;
            dout_func <= hbsc_pkg::DOUT_FUNC_RST;
        end else begin
            cur_lvl <= next_cur_lvl;
            freq_lvl <= next_freq_lvl;
            rel_tmr <= next_rel_tmr;
            apply_freq <= next_apply_freq;
            apply_tmr <= next_apply_tmr;
            torque_lvl <= next_torque_lvl;
            stop_freq <= next_stop_freq;
            speed_sel <= next_speed_sel;
            dout_func <= next_dout_func;
        end
    end

    // brake conditions; bit 1 of the word is read nowhere
    always_comb begin
        motor1 = motor_select == 2'h0;
        stop_event = output_shutdown || alarm || coast_cmd;
        // R6 slow path uses filtered current
        cur_diff = $signed({1'b0, output_current}) - $signed({1'b0, filt_cur});
        next_filt_cur = filt_cur +
            16'(cur_diff >>> hbsc_pkg::CURRENT_FILTER_SHIFT);
        cur_used = speed_sel[hbsc_pkg::SEL_QUICK_CURRENT] ?
            output_current : filt_cur;
        // R1 current level, or frequency (V/f) or torque (vector) level, above its threshold
        rel_cond = motor1 && !stop_event && (cur_used > cur_lvl ||
            (!vector_mode && output_freq > freq_lvl) ||
            (vector_mode && torque_cmd > torque_lvl));
        // R7 speed compared for apply
        speed_cmp = !vector_mode ? output_freq :
            (speed_sel[hbsc_pkg::SEL_REF_SPEED] ?
            reference_speed : detected_speed);
        // R8 apply frequency choice
        apply_thr = (!vector_mode || speed_sel[hbsc_pkg::SEL_APPLY_FREQ]) ?
            apply_freq : stop_freq;
        // R11 R12 run command gating
        run_ok = vector_mode ?
            (!speed_sel[hbsc_pkg::SEL_RUN_OFF_ONLY] || !run_cmd) : !run_cmd;
        apply_cond = speed_cmp < apply_thr && run_ok;
        rel_q = rel_if.qualified;
        apply_q = apply_if.qualified;
        rel_if.cond = state == hbsc_pkg::HBSC_ENGAGED && rel_cond;
        rel_if.limit = rel_tmr;
        apply_if.cond = state == hbsc_pkg::HBSC_RELEASED && apply_cond;
        apply_if.limit = apply_tmr;
        next_state = state;
        case (state)
            hbsc_pkg::HBSC_ENGAGED: begin
                // R1 release once qualified
                if (rel_q && rel_cond) begin
                    next_state = hbsc_pkg::HBSC_RELEASED;
                end
            end
            hbsc_pkg::HBSC_RELEASED: begin
                // R13 immediate apply on stop events
                if (stop_event || (apply_q && apply_cond)) begin
                    next_state = hbsc_pkg::HBSC_ENGAGED;
                end
            end
            default: next_state = hbsc_pkg::HBSC_ENGAGED;
        endcase
        // R14 other motors hold brake released
        next_brake = !motor1 || next_state == hbsc_pkg::HBSC_RELEASED;
        // R10 terminal routing
        next_dout = dout_func == hbsc_pkg::FUNC_BRAKE && next_brake;
    end

    // R16 engaged after reset
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state <= hbsc_pkg::HBSC_ENGAGED;
            filt_cur <= 16'h0000;
            brake_release_output <= 1'b0;
            dout_terminal <= 1'b0;
        end else begin
            state <= next_state;
            filt_cur <= next_filt_cur;
            brake_release_output <= next_brake;
            dout_terminal <= next_dout;
        end
    end

    a_release_after_qual: assert property ( // R1
        @(posedge clk) disable iff (!resetn)
        $rose(state == hbsc_pkg::HBSC_RELEASED) |-> $past(rel_q))
        else $error("brake released without qualification");

    a_current_range: assert property ( // R2
        @(posedge clk) disable iff (!resetn)
        cur_lvl <= hbsc_pkg::PERCENT_MAX && torque_lvl <= hbsc_pkg::PERCENT_MAX)
        else $error("percent level out of range");

    a_freq_vf_only: assert property ( // R3
        @(posedge clk) disable iff (!resetn)
        vector_mode && torque_cmd <= torque_lvl && cur_used <= cur_lvl
        |-> !rel_cond)
        else $error("frequency level used in vector control");

    a_quick_bypass: assert property ( // R6
        @(posedge clk) disable iff (!resetn)
        speed_sel[hbsc_pkg::SEL_QUICK_CURRENT] && motor1 && !stop_event &&
        output_current > cur_lvl |-> rel_cond)
        else $error("quick current path not taken");

    a_speed_select: assert property ( // R7
        @(posedge clk) disable iff (!resetn)
        vector_mode && speed_sel[hbsc_pkg::SEL_REF_SPEED]
        |-> speed_cmp == reference_speed)
        else $error("wrong speed for apply");

    a_apply_threshold: assert property ( // R8
        @(posedge clk) disable iff (!resetn)
        vector_mode && !speed_sel[hbsc_pkg::SEL_APPLY_FREQ]
        |-> apply_thr == stop_freq)
        else $error("wrong apply threshold");

    a_terminal_route: assert property ( // R10
        @(posedge clk) disable iff (!resetn)
        dout_func == hbsc_pkg::FUNC_BRAKE ##1 dout_func == hbsc_pkg::FUNC_BRAKE
        |-> dout_terminal == brake_release_output)
        else $error("terminal does not follow brake signal");

    a_run_gate_vf: assert property ( // R11
        @(posedge clk) disable iff (!resetn)
        !vector_mode && run_cmd |-> !apply_cond)
        else $error("apply allowed with run on");

    a_stop_engages: assert property ( // R13
        @(posedge clk) disable iff (!resetn)
        stop_event && motor1 |=> !brake_release_output)
        else $error("stop event did not apply brake");

    a_other_motor: assert property ( // R14
        @(posedge clk) disable iff (!resetn)
        !motor1 |=> brake_release_output)
        else $error("brake applied on other motor");
endmodule
`default_nettype wire

// [design/hbsc_pkg.sv]
// constants, types and register map of the hoist brake signal control
// assumes a 10 MHz control clock and an axi4-lite register bus
package hbsc_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int LVL_W = 16;
    localparam int SEL_W = 5;
    localparam int FUNC_W = 8;

    // register byte offsets
    localparam logic [7:0] OFS_RELEASE_CURRENT = 8'h00;
    localparam logic [7:0] OFS_RELEASE_FREQ = 8'h04;
    localparam logic [7:0] OFS_RELEASE_TIMER = 8'h08;
    localparam logic [7:0] OFS_APPLY_FREQ = 8'h0C;
    localparam logic [7:0] OFS_APPLY_TIMER = 8'h10;
    localparam logic [7:0] OFS_RELEASE_TORQUE = 8'h14;
    localparam logic [7:0] OFS_SPEED_SEL = 8'h18;
    localparam logic [7:0] OFS_STOP_FREQ = 8'h1C;
    localparam logic [7:0] OFS_DOUT_FUNC = 8'h20;
    localparam logic [7:0] OFS_STATUS = 8'h24;

    // upper limits of the settings
    localparam logic [15:0] PERCENT_MAX = 16'h012C;
    localparam logic [15:0] FREQ_MAX = 16'h00FA;
    localparam logic [15:0] TIMER_MAX = 16'h0032;
    localparam logic [4:0] SEL_MAX = 5'h1F;

    // reset values
    localparam logic [15:0] PERCENT_RST = 16'h0064;
    localparam logic [15:0] FREQ_RST = 16'h000A;
    localparam logic [15:0] TIMER_RST = 16'h000A;
    localparam logic [4:0] SEL_RST = 5'h00;
    localparam logic [15:0] STOP_FREQ_RST = 16'h0005;
    localparam logic [7:0] DOUT_FUNC_RST = 8'h00;

    // terminal function code that routes the brake signal
    localparam logic [7:0] FUNC_BRAKE = 8'h39;

    // speed-condition word bit positions
    localparam int SEL_REF_SPEED = 0;
    localparam int SEL_QUICK_CURRENT = 2;
    localparam int SEL_APPLY_FREQ = 3;
    localparam int SEL_RUN_OFF_ONLY = 4;

    // status bit positions
    localparam int ST_BIT_RELEASED = 0;
    localparam int ST_BIT_REL_COND = 1;
    localparam int ST_BIT_APPLY_COND = 2;
    localparam int ST_BIT_MOTOR1 = 3;

    localparam int CURRENT_FILTER_SHIFT = 3;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // timer step of 0.1 s
    localparam longint TICK_NS = 100000000;
    localparam longint CLK_PERIOD_NS = 100;
    localparam int TICK_CYCLES = int'(TICK_NS / CLK_PERIOD_NS);

    typedef enum logic [1:0] {
        HBSC_ENGAGED = 2'b01,
        HBSC_RELEASED = 2'b10
    } hbsc_state_type;

endpackage

// [design/hbsc_timer_if.sv]
// link between the brake control and one qualification timer
// assumes both ends share one clock
`timescale 1ns/1ns
`default_nettype none
interface hbsc_timer_if;
    logic cond;
    logic [15:0] limit;
    logic qualified;
    modport user (output cond, output limit, input qualified);
    modport timer (input cond, input limit, output qualified);
endinterface
`default_nettype wire

// [design/hbsc_qual_timer.sv]
// qualification timer counting whole 0.1 s steps while a condition holds
// assumes cond comes from logic on the same clock
`timescale 1ns/1ns
`default_nettype none
module hbsc_qual_timer #(
    parameter int TICK_CYCLES = hbsc_pkg::TICK_CYCLES
) (
    input wire logic clk,
    input wire logic resetn,
    hbsc_timer_if.timer tif
);
    localparam int SUB_W = $clog2(TICK_CYCLES + 1);
    localparam logic [SUB_W-1:0] SUB_LAST = SUB_W'(TICK_CYCLES - 1);

    logic [SUB_W-1:0] sub;
    logic [15:0] ticks;
    logic qualified;
    logic [SUB_W-1:0] next_sub;
    logic [15:0] next_ticks;
    logic next_qualified;

    always_comb begin
        next_sub = sub;
        next_ticks = ticks;
        next_qualified = tif.cond && (ticks >= tif.limit);
        // R15 restart on false
        if (!tif.cond) begin
            next_sub = '0;
            next_ticks = '0;
        end else if (ticks < tif.limit) begin
            if (sub == SUB_LAST) begin
                next_sub = '0;
                next_ticks = ticks + 16'h0001;
            end else begin
                next_sub = sub + SUB_W'(1);
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sub <= '0;
            ticks <= '0;
            qualified <= 1'b0;
        end else begin
            sub <= next_sub;
            ticks <= next_ticks;
            qualified <= next_qualified;
        end
    end

    assign tif.qualified = qualified;

    a_timer_restart: assert property ( // R15
        @(posedge clk) disable iff (!resetn)
        !tif.cond |=> !qualified && ticks == 16'h0000)
        else $error("timer did not restart");

    a_timer_full: assert property ( // R5
        @(posedge clk) disable iff (!resetn)
        $rose(qualified) |-> $past(ticks) >= $past(tif.limit))
        else $error("timer qualified early");
endmodule
`default_nettype wire

// [bench/hbsc_brake_model.sv]
// mechanical brake actuator on the hoist
// assumes the release command is a level on clk
`timescale 1ns/1ns
`default_nettype none
module hbsc_brake_model (
    input wire logic clk,
    input wire logic release_cmd,
    output logic held_open
);
    // lining lifts one cycle after the coil is fed
    logic lift;
    always_ff @(posedge clk) begin
        lift <= release_cmd;
        held_open <= lift & release_cmd;
    end
endmodule
`default_nettype wire

// [bench/hoist_brake_signal_control_tb.sv]
// bench for the hoist brake signal control
// assumes design sources and brake model compiled first
`timescale 1ns/1ns
`default_nettype none
module hoist_brake_signal_control_tb;
logic clk = 0, resetn = 0, awvalid = 0, wvalid = 0, bready = 0;
logic arvalid = 0, rready = 0, awready, wready, bvalid, arready, rvalid;
logic vec = 0, run = 0, shut = 0, alm = 0, coast = 0, brk, dout, held;
logic [7:0] awaddr = 0, araddr = 0;
logic [31:0] wdata = 0, rdata;
logic [1:0] bresp, rresp, msel = 0;
logic [15:0] cur = 0, frq = 0, trq = 0, spd = 0;
logic [33:0] exp_q[$];
int error_cnt = 0, n_checks = 0, seed = 9, cyc = 0;
always #50 clk = ~clk;
hoist_brake_signal_control #(.TICK_CYCLES(4)) dut (.clk(clk),
    .resetn(resetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .output_current(cur), .output_freq(frq), .torque_cmd(trq),
    .detected_speed(frq), .reference_speed(spd), .vector_mode(vec),
    .run_cmd(run), .output_shutdown(shut), .alarm(alm),
    .coast_cmd(coast), .motor_select(msel), .brake_release_output(brk),
    .dout_terminal(dout));
hbsc_brake_model brake (.clk(clk), .release_cmd(brk), .held_open(held));
task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
        $display("Result: passed");
    else
        $display("Result: failed");
    $finish;
endtask
task automatic cmp(string n, logic [33:0] e, logic [33:0] s);
    n_checks++;
    if (s !== e) begin
        error_cnt++;
        $display("MISMATCH %s exp %h got %h", n, e, s);
    end
endtask
task automatic wr(logic [7:0] a, logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    do begin
        @(posedge clk);
        if (awready) awvalid <= 0;
        if (wready) wvalid <= 0;
    end while (bvalid !== 1);
    bready <= 0;
    cmp("bresp", 34'h0, 34'(bresp));
    // one idle edge so the next call never re-raises bready in this step
    @(posedge clk);
endtask
task automatic rd(logic [7:0] a, logic [33:0] e);
    exp_q.push_back(e);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do begin
        @(posedge clk);
        if (arready) arvalid <= 0;
    end while (rvalid !== 1);
    rready <= 0;
    @(posedge clk);
endtask
task automatic wait_brk(logic v, int lim);
    for (int i = 0; i < lim && brk !== v; i++) @(posedge clk);
    cmp("brake", 34'(v), 34'(brk));
endtask
// read results checked as they appear
always @(posedge clk) begin
    if (rvalid === 1 && rready === 1 && exp_q.size() > 0)
        cmp("rdata", exp_q.pop_front(), {rresp, rdata});
end
always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
        error_cnt++;
        close_out();
    end
end
initial begin
    repeat (6) @(posedge clk);
    resetn <= 1;
    @(posedge clk);
    cmp("brake", 34'h0, 34'(brk));
    rd(8'h18, 34'h0);
    rd(8'h00, 34'h64);
    rd(8'h40, 34'h200000000);
    wr(8'h00, 32'h190);
    rd(8'h00, 34'h12C);
    $display("registers done");
    wr(8'h00, 32'h32);
    wr(8'h08, 32'h1);
    wr(8'h18, 32'h6);
    wr(8'h20, 32'h39);
    cur <= 16'h33 + {8'h00, 8'($random(seed))};
    repeat (3) @(posedge clk);
    cur <= 0;
    repeat (8) @(posedge clk);
    cmp("brake", 34'h0, 34'(brk));
    cur <= 16'h33 + {8'h00, 8'($random(seed))};
    wait_brk(1, 12);
    @(posedge clk);
    cmp("dout", 34'h1, 34'(dout));
    @(posedge clk);
    cmp("held", 34'h1, 34'(held));
    cur <= 0;
    wait_brk(0, 60);
    msel <= 2'h2;
    wait_brk(1, 4);
    msel <= 0;
    cur <= 16'h40;
    $display("release and apply done");
    // back on motor 1 the brake must engage before it may release again
    wait_brk(0, 4);
    wait_brk(1, 12);
    alm <= 1;
    wait_brk(0, 3);
    $display("stop event done");
    alm <= 0;
    cur <= 0;
    vec <= 1;
    run <= 1;
    spd <= 16'h50;
    wr(8'h10, 32'h1);
    wr(8'h18, 32'h19);
    trq <= 16'h70;
    wait_brk(1, 12);
    spd <= 16'h0;
    repeat (12) @(posedge clk);
    cmp("brake", 34'h1, 34'(brk));
    run <= 0;
    spd <= 16'h50;
    repeat (12) @(posedge clk);
    cmp("brake", 34'h1, 34'(brk));
    // 0.7 Hz lies between stop and apply frequency
    trq <= 0;
    spd <= 16'h7;
    wait_brk(0, 12);
    $display("vector control done");
    close_out();
end
endmodule
`default_nettype wire
